/* File: rtl/ifs_pkg.sv */
// Package for the instruction fetch sequencer: offsets, fields, reset values, types
package ifs_pkg;

  // ==========================================================================
  // Register offsets (byte addresses, word aligned)
  // ==========================================================================
  // Shadow offsets are register indices; the byte address is four times each
  localparam logic [7:0] OFS_ERR_STATUS_ONE = 8'h43;
  localparam logic [7:0] OFS_SCRATCH_B      = 8'h5c;
  localparam logic [7:0] OFS_SCRATCH_C      = 8'h60;
  localparam logic [7:0] OFS_MEM_RD_SEL     = 8'ha0;
  localparam logic [7:0] OFS_MEM_WR_SEL     = 8'ha4;
  localparam logic [7:0] OFS_FETCH_SEL      = 8'ha8;
  localparam logic [9:0] ADR_ERR_STATUS_ONE = {OFS_ERR_STATUS_ONE, 2'b00};
  localparam logic [9:0] ADR_SCRATCH_B      = {OFS_SCRATCH_B, 2'b00};
  localparam logic [9:0] ADR_SCRATCH_C      = {OFS_SCRATCH_C, 2'b00};
  // Sixteen scratch words, C to R
  localparam logic [9:0] ADR_SCRATCH_END    = ADR_SCRATCH_C + 10'h03c;
  localparam logic [9:0] ADR_MEM_RD_SEL     = {OFS_MEM_RD_SEL, 2'b00};
  localparam logic [9:0] ADR_MEM_WR_SEL     = {OFS_MEM_WR_SEL, 2'b00};
  localparam logic [9:0] ADR_FETCH_SEL      = {OFS_FETCH_SEL, 2'b00};
  localparam logic [9:0] ADR_PROG_PTR       = 10'h200;
  localparam logic [9:0] ADR_CONTROL        = 10'h204;
  localparam logic [9:0] ADR_STATUS         = 10'h208;
  localparam logic [9:0] ADR_CMD_COUNT      = 10'h20c;
  localparam logic [9:0] ADR_PTR_SAVE       = 10'h210;
  localparam logic [9:0] ADR_TEMP           = 10'h214;
  localparam logic [9:0] ADR_DATA_ADDR      = 10'h218;
  localparam logic [9:0] ADR_TEST_FOUR      = 10'h21c;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int BIT_SHADOW_ACCESS = 4;
  localparam int BIT_SRC_IO        = 5;
  localparam int BIT_DST_IO        = 4;
  localparam int BIT_PAD_NO_CRC    = 5;
  localparam int BIT_FORCED_CRC    = 4;
  localparam int BIT_TIMING_SWITCH = 3;
  localparam int BIT_NO_FINAL_CRC  = 2;
  localparam int BIT_REPEAT_CRC    = 1;
  localparam logic [7:0] ERR_ONE_MASK = 8'h3e;

  // Opcode classes of the top byte
  localparam logic [1:0] OPC_BLOCK_MOVE = 2'h0;
  localparam logic [1:0] OPC_IO         = 2'h1;
  localparam logic [1:0] OPC_XFER_CTRL  = 2'h2;
  localparam logic [1:0] OPC_MEM_MOVE   = 2'h3;
  localparam logic [7:0] OPC_INTERRUPT  = 8'h98;

  // Interrupt causes in the status register
  localparam logic [1:0] CAUSE_NONE    = 2'h0;
  localparam logic [1:0] CAUSE_INT_OP  = 2'h1;
  localparam logic [1:0] CAUSE_ILLEGAL = 2'h2;
  localparam logic [1:0] CAUSE_ERROR   = 2'h3;

  // Reset values
  localparam logic [31:0] RST_WORD      = 32'h0000_0000;
  localparam logic [7:0]  RST_ERR_ONE   = 8'h00;
  localparam logic [31:0] RST_FETCH_SEL = 32'h0000_0000;
  localparam logic [15:0] RST_BURST_LEN = 16'h0004;

  localparam logic [31:0] INSN_WORD_BYTES = 32'h0000_0004;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [3:0] {
    ST_IDLE, ST_FETCH, ST_DECODE, ST_EXTRA, ST_WAIT_FIFO, ST_BUS_REQ, ST_BURST, ST_HALT
  } ifs_state_t;

  typedef struct packed {
    logic        req;
    logic        from_ram;
    logic [31:0] addr;
  } ifs_fetch_req_t;

  typedef struct packed {
    logic        req;
    logic        to_mem;
    logic        io_space;
    logic [31:0] addr;
    logic [15:0] len;
  } ifs_burst_req_t;

endpackage

/* File: rtl/ifs_sequencer.sv */
// Instruction fetch and execute sequencer with its APB register file
`timescale 1ns/10ps
module ifs_sequencer #(
  parameter logic [31:0] RAM_BASE = 32'hffff_0000,
  parameter logic [31:0] RAM_MASK = 32'hffff_0000
) (
  input  wire logic                   CLK_I,
  input  wire logic                   RST_B_I,
  input  wire logic                   CE_I,
  input  wire logic                   PSEL_I,
  input  wire logic                   PENABLE_I,
  input  wire logic                   PWRITE_I,
  input  wire logic [9:0]             PADDR_I,
  input  wire logic [31:0]            PWDATA_I,
  output logic      [31:0]            PRDATA_O,
  output logic                        PREADY_O,
  output logic                        PSLVERR_O,
  output ifs_pkg::ifs_fetch_req_t     FETCH_O,
  input  wire logic                   FETCH_ACK_I,
  input  wire logic [31:0]            FETCH_DATA_I,
  input  wire logic                   FIFO_READY_I,
  output ifs_pkg::ifs_burst_req_t     BURST_O,
  input  wire logic                   BUS_GNT_I,
  input  wire logic                   BURST_DONE_I,
  input  wire logic                   HW_ERROR_I,
  input  wire logic [7:0]             CRC_FAULT_I,
  output logic                        HALTED_O,
  output logic                        IRQ_O
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    ifs_pkg::ifs_state_t     st;
    logic [31:0]             prog_ptr;
    logic [31:0]             cmd_count;
    logic [31:0]             ptr_save;
    logic [31:0]             temp;
    logic [31:0]             data_addr;
    logic [1:0]              words_left;
    logic [1:0]              word_idx;
    logic [1:0]              cause;
    logic [7:0]              dma_mode;
    logic [15:0]             burst_len;
    logic [7:0]              test_four;
    logic                    low_level;
    logic [7:0]              err_one;
    logic [31:0]             scratch_b;
    logic [31:0]             mem_rd_sel;
    logic [31:0]             mem_wr_sel;
    logic [31:0]             fetch_sel;
    logic [31:0]             prdata;
    logic                    pready;
    logic                    pslverr;
    ifs_pkg::ifs_fetch_req_t fetch;
    ifs_pkg::ifs_burst_req_t burst;
    logic                    irq;
    logic                    halted;
  } ifs_regs_t;

  ifs_regs_t   r_q;
  ifs_regs_t   r_d;
  logic [31:0] scratch_q [16];
  logic        apb_acc;
  logic        apb_wr;
  logic        shadow_on;
  logic [3:0]  scr_idx;
  logic        scr_hit;
  logic [31:0] chunk;

  assign apb_acc   = PSEL_I && PENABLE_I && !r_q.pready;
  assign apb_wr    = apb_acc && PWRITE_I;
  assign shadow_on = r_q.test_four[ifs_pkg::BIT_SHADOW_ACCESS];
  assign scr_idx   = PADDR_I[5:2];
  assign scr_hit   = PADDR_I >= ifs_pkg::ADR_SCRATCH_C && PADDR_I <= ifs_pkg::ADR_SCRATCH_END;
  // Burst never exceeds the remaining count, so the count cannot wrap
  assign chunk     = ({8'h00, r_q.cmd_count[23:0]} < {16'h0000, r_q.burst_len}) ?
                     {8'h00, r_q.cmd_count[23:0]} : {16'h0000, r_q.burst_len};

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    r_d         = r_q;
    r_d.pready  = 1'b0;
    r_d.pslverr = 1'b0;
    // Hardware set is applied after the write-one clear so the set wins
    if (apb_wr && PADDR_I == ifs_pkg::ADR_ERR_STATUS_ONE && shadow_on) begin
      r_d.err_one = r_q.err_one & ~PWDATA_I[7:0];
    end
    r_d.err_one = (r_d.err_one | CRC_FAULT_I) & ifs_pkg::ERR_ONE_MASK;
    if (apb_acc) begin
      r_d.pready = 1'b1;
      r_d.prdata = 32'h0000_0000;
      if (PWRITE_I) begin
        unique case (PADDR_I)
          ifs_pkg::ADR_ERR_STATUS_ONE: r_d.pslverr = !shadow_on;
          ifs_pkg::ADR_SCRATCH_B:   r_d.scratch_b  = PWDATA_I;
          ifs_pkg::ADR_MEM_RD_SEL:  r_d.mem_rd_sel = PWDATA_I;
          ifs_pkg::ADR_MEM_WR_SEL:  r_d.mem_wr_sel = PWDATA_I;
          ifs_pkg::ADR_FETCH_SEL:   r_d.fetch_sel  = PWDATA_I;
          ifs_pkg::ADR_CONTROL: begin
            r_d.dma_mode  = PWDATA_I[7:0];
            r_d.low_level = PWDATA_I[8];
            r_d.burst_len = (PWDATA_I[31:16] == 16'h0000) ? ifs_pkg::RST_BURST_LEN
                                                          : PWDATA_I[31:16];
          end
          ifs_pkg::ADR_TEST_FOUR:   r_d.test_four  = PWDATA_I[7:0];
          ifs_pkg::ADR_PROG_PTR:    r_d.pslverr = 1'b0;
          default: r_d.pslverr = !scr_hit;
        endcase
      end else begin
        unique case (PADDR_I)
          ifs_pkg::ADR_ERR_STATUS_ONE: begin
            r_d.prdata  = shadow_on ? {24'h0, r_q.err_one} : 32'h0;
            r_d.pslverr = !shadow_on;
          end
          ifs_pkg::ADR_SCRATCH_B:   r_d.prdata = r_q.scratch_b;
          ifs_pkg::ADR_MEM_RD_SEL:  r_d.prdata = r_q.mem_rd_sel;
          ifs_pkg::ADR_MEM_WR_SEL:  r_d.prdata = r_q.mem_wr_sel;
          ifs_pkg::ADR_FETCH_SEL:   r_d.prdata = r_q.fetch_sel;
          ifs_pkg::ADR_PROG_PTR:    r_d.prdata = r_q.prog_ptr;
          ifs_pkg::ADR_CONTROL:     r_d.prdata = {r_q.burst_len, 7'h0, r_q.low_level,
                                                  r_q.dma_mode};
          ifs_pkg::ADR_STATUS:      r_d.prdata = {24'h0, r_q.cause, r_q.st == ifs_pkg::ST_HALT,
                                                  1'b0, 4'(r_q.st)};
          ifs_pkg::ADR_CMD_COUNT:   r_d.prdata = r_q.cmd_count;
          ifs_pkg::ADR_PTR_SAVE:    r_d.prdata = r_q.ptr_save;
          ifs_pkg::ADR_TEMP:        r_d.prdata = r_q.temp;
          ifs_pkg::ADR_DATA_ADDR:   r_d.prdata = r_q.data_addr;
          ifs_pkg::ADR_TEST_FOUR:   r_d.prdata = {24'h0, r_q.test_four};
          default: begin
            r_d.prdata  = scr_hit ? scratch_q[scr_idx] : 32'h0;
            r_d.pslverr = !scr_hit;
          end
        endcase
      end
    end

    unique case (r_q.st)
      ifs_pkg::ST_IDLE: ;
      ifs_pkg::ST_FETCH: begin
        r_d.fetch.req      = 1'b1;
        r_d.fetch.addr     = r_q.prog_ptr;
        r_d.fetch.from_ram = (r_q.prog_ptr & RAM_MASK) == RAM_BASE;
        if (r_q.fetch.req && FETCH_ACK_I) begin
          r_d.fetch.req = 1'b0;
          r_d.prog_ptr  = r_q.prog_ptr + ifs_pkg::INSN_WORD_BYTES;
          unique case (r_q.word_idx)
            2'h0:    r_d.cmd_count = FETCH_DATA_I;
            2'h1:    r_d.ptr_save  = FETCH_DATA_I;
            default: r_d.temp      = FETCH_DATA_I;
          endcase
          r_d.word_idx = r_q.word_idx + 2'h1;
          // Memory moves take a third word: 12 bytes, else 8
          if (r_q.word_idx == 2'h2 ||
              (r_q.word_idx == 2'h1 && r_q.cmd_count[31:30] != ifs_pkg::OPC_MEM_MOVE)) begin
            r_d.st = ifs_pkg::ST_DECODE;
          end
        end
      end
      ifs_pkg::ST_DECODE: begin
        r_d.data_addr = r_q.ptr_save;
        r_d.word_idx  = 2'h0;
        if (HW_ERROR_I) begin
          r_d.st    = ifs_pkg::ST_HALT;
          r_d.cause = ifs_pkg::CAUSE_ERROR;
        end else if (r_q.cmd_count[31:24] == ifs_pkg::OPC_INTERRUPT) begin
          r_d.st    = ifs_pkg::ST_HALT;
          r_d.cause = ifs_pkg::CAUSE_INT_OP;
        end else if (r_q.cmd_count[31:30] == ifs_pkg::OPC_BLOCK_MOVE) begin
          // Indirect flag: one extra word holding the real data address
          r_d.words_left = r_q.cmd_count[29] ? 2'h1 : 2'h0;
          r_d.st = r_q.cmd_count[29] ? ifs_pkg::ST_EXTRA : ifs_pkg::ST_WAIT_FIFO;
        end else if (r_q.cmd_count[31:30] == ifs_pkg::OPC_IO && !r_q.cmd_count[27]) begin
          // Relative form fetches two words; other I/O needs none here
          r_d.words_left = r_q.cmd_count[26] ? 2'h2 : 2'h0;
          r_d.st = r_q.cmd_count[26] ? ifs_pkg::ST_EXTRA : ifs_pkg::ST_FETCH;
        end else if (r_q.cmd_count[31:30] == ifs_pkg::OPC_XFER_CTRL ||
                     r_q.cmd_count[31:30] == ifs_pkg::OPC_MEM_MOVE) begin
          r_d.st = ifs_pkg::ST_FETCH;
        end else begin
          r_d.st    = ifs_pkg::ST_HALT;
          r_d.cause = ifs_pkg::CAUSE_ILLEGAL;
        end
      end
      ifs_pkg::ST_EXTRA: begin
        r_d.fetch.req      = 1'b1;
        r_d.fetch.addr     = r_q.data_addr;
        r_d.fetch.from_ram = (r_q.data_addr & RAM_MASK) == RAM_BASE;
        if (r_q.fetch.req && FETCH_ACK_I) begin
          r_d.fetch.req   = 1'b0;
          r_d.data_addr   = (r_q.words_left == 2'h2) ? r_q.data_addr + ifs_pkg::INSN_WORD_BYTES
                                                     : FETCH_DATA_I;
          if (r_q.words_left == 2'h2) begin
            r_d.cmd_count[23:0] = FETCH_DATA_I[23:0];
          end
          r_d.words_left = r_q.words_left - 2'h1;
          if (r_q.words_left == 2'h1) begin
            r_d.st = (r_q.cmd_count[31:30] == ifs_pkg::OPC_BLOCK_MOVE) ?
                     ifs_pkg::ST_WAIT_FIFO : ifs_pkg::ST_FETCH;
          end
        end
      end
      ifs_pkg::ST_WAIT_FIFO: begin
        if (r_q.cmd_count[23:0] == 24'h0) begin
          r_d.st = ifs_pkg::ST_FETCH;
        end else if (HW_ERROR_I) begin
          r_d.st    = ifs_pkg::ST_HALT;
          r_d.cause = ifs_pkg::CAUSE_ERROR;
        end else if (FIFO_READY_I) begin
          r_d.st = ifs_pkg::ST_BUS_REQ;
        end
      end
      ifs_pkg::ST_BUS_REQ: begin
        r_d.burst.req      = 1'b1;
        r_d.burst.addr     = r_q.data_addr;
        r_d.burst.len      = chunk[15:0];
        // Opcode bit 24 set means data flows in from the storage bus
        r_d.burst.to_mem   = r_q.cmd_count[24];
        r_d.burst.io_space = r_q.cmd_count[24] ? r_q.dma_mode[ifs_pkg::BIT_DST_IO]
                                               : r_q.dma_mode[ifs_pkg::BIT_SRC_IO];
        if (r_q.burst.req && BUS_GNT_I) begin
          r_d.st = ifs_pkg::ST_BURST;
        end
      end
      ifs_pkg::ST_BURST: begin
        if (BURST_DONE_I) begin
          r_d.burst.req       = 1'b0;
          r_d.cmd_count[23:0] = r_q.cmd_count[23:0] - chunk[23:0];
          r_d.data_addr       = r_q.data_addr + chunk;
          r_d.st              = ifs_pkg::ST_WAIT_FIFO;
        end
      end
      ifs_pkg::ST_HALT: begin
        r_d.irq   = 1'b1;
        r_d.fetch.req = 1'b0;
        r_d.burst.req = 1'b0;
      end
      default: r_d.st = ifs_pkg::ST_IDLE;
    endcase

    // Pointer write comes last; with low_level clear it wins over the running sequence and the halt
    if (apb_wr && PADDR_I == ifs_pkg::ADR_PROG_PTR) begin
      // Low two bits are dropped: the host owes aligned addresses
      r_d.prog_ptr = {PWDATA_I[31:2], 2'b00};
      if (!r_q.low_level) begin
        r_d.st        = ifs_pkg::ST_FETCH;
        r_d.word_idx  = 2'h0;
        r_d.cause     = ifs_pkg::CAUSE_NONE;
        r_d.irq       = 1'b0;
        r_d.fetch.req = 1'b0;
        r_d.burst.req = 1'b0;
      end
    end
    r_d.halted = r_d.st == ifs_pkg::ST_HALT;
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      r_q           <= '0;
      r_q.st        <= ifs_pkg::ST_IDLE;
      r_q.err_one   <= ifs_pkg::RST_ERR_ONE;
      r_q.fetch_sel <= ifs_pkg::RST_FETCH_SEL;
      r_q.burst_len <= ifs_pkg::RST_BURST_LEN;
    end else if (CE_I) begin
      r_q <= r_d;
    end
  end

  // Scratch array has no reset, as its contents are undefined at power-up
  always_ff @(posedge CLK_I) begin
    if (CE_I && apb_wr && scr_hit) begin
      scratch_q[scr_idx] <= PWDATA_I;
    end
  end

  assign PRDATA_O  = r_q.prdata;
  assign PREADY_O  = r_q.pready;
  assign PSLVERR_O = r_q.pslverr;
  assign FETCH_O   = r_q.fetch;
  assign BURST_O   = r_q.burst;
  assign HALTED_O  = r_q.halted;
  assign IRQ_O     = r_q.irq;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  sequence burst_end_s;
    r_q.st == ifs_pkg::ST_BURST && BURST_DONE_I && CE_I;
  endsequence

  halt_holds_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (r_q.st == ifs_pkg::ST_HALT && !apb_wr) |=> r_q.st == ifs_pkg::ST_HALT)
    else $error("halt left without pointer write");
  restart_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (CE_I && apb_wr && PADDR_I == ifs_pkg::ADR_PROG_PTR && !r_q.low_level)
    |=> r_q.st == ifs_pkg::ST_FETCH && r_q.prog_ptr == {$past(PWDATA_I[31:2]), 2'b00})
    else $error("pointer write did not restart fetch");
  ptr_step_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (CE_I && r_q.st == ifs_pkg::ST_FETCH && r_q.fetch.req && FETCH_ACK_I && !apb_wr)
    |=> r_q.prog_ptr == $past(r_q.prog_ptr) + 32'h4)
    else $error("pointer did not step one word");
  count_down_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    burst_end_s |=> r_q.cmd_count[23:0] == $past(r_q.cmd_count[23:0]) - $past(chunk[23:0])
                   && !r_q.burst.req)
    else $error("burst did not lower count");
  no_req_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (CE_I && r_q.st == ifs_pkg::ST_WAIT_FIFO && !FIFO_READY_I && !apb_wr)
    |=> r_q.st != ifs_pkg::ST_BUS_REQ)
    else $error("bus requested without fifo room");
  shadow_gate_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (CE_I && apb_acc && !PWRITE_I && PADDR_I == ifs_pkg::ADR_ERR_STATUS_ONE && !shadow_on)
    |=> PRDATA_O == 32'h0 && PSLVERR_O)
    else $error("shadow status read while hidden");
  illegal_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (CE_I && r_q.st == ifs_pkg::ST_HALT && r_q.cause == ifs_pkg::CAUSE_ILLEGAL && !apb_wr)
    |=> IRQ_O)
    else $error("illegal opcode raised no interrupt");
  space_sel_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (r_q.burst.req && !r_q.burst.to_mem) |-> r_q.burst.io_space ==
     r_q.dma_mode[ifs_pkg::BIT_SRC_IO])
    else $error("source space bit ignored");
  zero_fetch_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (CE_I && r_q.st == ifs_pkg::ST_WAIT_FIFO && r_q.cmd_count[23:0] == 24'h0 && !apb_wr)
    |=> r_q.st == ifs_pkg::ST_FETCH)
    else $error("zero count did not fetch next");

endmodule

/* File: tb/ifs_host_model.sv */
// Behavioural host memory and bus arbiter facing the sequencer
`timescale 1ns/10ps
module ifs_host_model (
  input  wire logic               clk_i,
  input  wire logic               rst_b_i,
  input  ifs_pkg::ifs_fetch_req_t fetch_i,
  input  ifs_pkg::ifs_burst_req_t burst_i,
  output logic                    fetch_ack_o,
  output logic [31:0]             fetch_data_o,
  output logic                    bus_gnt_o,
  output logic                    burst_done_o,
  output int                      bursts_o,
  output logic [31:0]             last_addr_o
);
  logic [31:0] mem [0:15];
  logic [1:0]  wait_q;
  logic [1:0]  slow_q;
  // ==========================================================================
  // Fetch answers alternate prompt and slow; idle data scrambles so stale words fail
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      fetch_ack_o <= 1'b0;
      fetch_data_o <= 32'h0;
      bus_gnt_o <= 1'b0;
      burst_done_o <= 1'b0;
      bursts_o <= 0;
      last_addr_o <= 32'h0;
      wait_q <= 2'h0;
      slow_q <= 2'h0;
    end else begin
      fetch_ack_o <= 1'b0;
      fetch_data_o <= ~fetch_data_o;
      burst_done_o <= 1'b0;
      if (fetch_i.req && !fetch_ack_o) begin
        wait_q <= wait_q + 2'h1;
        if (wait_q == slow_q) begin
          fetch_ack_o <= 1'b1;
          fetch_data_o <= mem[fetch_i.addr[5:2]];
          wait_q <= 2'h0;
          slow_q <= slow_q ^ 2'h2;
        end
      end
      if (burst_i.req && !bus_gnt_o) begin
        bus_gnt_o <= 1'b1;
        bursts_o <= bursts_o + 1;
        last_addr_o <= burst_i.addr;
      end
      if (bus_gnt_o && !burst_done_o) burst_done_o <= 1'b1;
      if (burst_done_o) bus_gnt_o <= 1'b0;
    end
  end
endmodule

/* File: tb/ifs_sequencer_tb_top.sv */
// Self-checking bench for the instruction fetch sequencer
`timescale 1ns/10ps
module ifs_sequencer_tb_top;
  logic clk, rst_b, psel, pen, pwr, fifo, gnt, done, ack, halted, irq, pready, pslverr, err;
  logic hw, fram, fbad;
  logic [9:0] paddr;
  logic [31:0] pwdata, prdata, rd, fdata, last_addr;
  logic [7:0] crc;
  ifs_pkg::ifs_fetch_req_t fetch;
  ifs_pkg::ifs_burst_req_t burst, bcap;
  int num_errors = 0, comparisons = 0, cycles = 0, bursts;
  ifs_sequencer ifs_sequencer_i (.CLK_I(clk), .RST_B_I(rst_b), .CE_I(1'b1), .PSEL_I(psel),
    .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .FETCH_O(fetch), .FETCH_ACK_I(ack),
    .FETCH_DATA_I(fdata), .FIFO_READY_I(fifo), .BURST_O(burst), .BUS_GNT_I(gnt),
    .BURST_DONE_I(done), .HW_ERROR_I(hw), .CRC_FAULT_I(crc), .HALTED_O(halted), .IRQ_O(irq));
  ifs_host_model ifs_host_model_i (.clk_i(clk), .rst_b_i(rst_b), .fetch_i(fetch),
    .burst_i(burst), .fetch_ack_o(ack), .fetch_data_o(fdata), .bus_gnt_o(gnt),
    .burst_done_o(done), .bursts_o(bursts), .last_addr_o(last_addr));
  // ==========================================================================
  // Clock, watchdog and shared tasks
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      results();
    end
  end
  task check(string n, logic [31:0] s, logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  // Holds the request until pready is seen at an edge
  task apb(logic w, logic [9:0] a, logic [31:0] d);
    int t;
    psel <= 1'b1; pen <= 1'b0; pwr <= w; paddr <= a; pwdata <= d;
    @(posedge clk) pen <= 1'b1;
    t = 0;
    do begin @(posedge clk); t++; end while (pready !== 1'b1 && t < 50);
    if (pready !== 1'b1) num_errors++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  task wait_irq;
    int t;
    t = 0;
    do begin
      @(posedge clk);
      t++;
      if (burst.req === 1'b1) bcap = burst;
      if (fetch.req === 1'b1) begin
        fram = fram | fetch.from_ram;
        if (fetch.from_ram !== (fetch.addr[31:16] == 16'hffff)) fbad = 1'b1;
      end
    end while (irq !== 1'b1 && t < 400);
    if (irq !== 1'b1) num_errors++;
  endtask
  task results;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // ==========================================================================
  // Scenarios
  task regs;
    apb(1'b0, ifs_pkg::ADR_FETCH_SEL, 32'h0); check("fetch sel", rd, ifs_pkg::RST_FETCH_SEL);
    apb(1'b1, ifs_pkg::ADR_SCRATCH_B, 32'h5a5a_0ff0);
    apb(1'b0, ifs_pkg::ADR_SCRATCH_B, 32'h0); check("scratch b", rd, 32'h5a5a_0ff0);
    apb(1'b0, 10'h3fc, 32'h0); check("unmapped", {31'h0, err}, 32'h1);
    apb(1'b0, ifs_pkg::ADR_ERR_STATUS_ONE, 32'h0); check("hidden", {31'h0, err}, 32'h1);
  endtask
  task crc_faults;
    apb(1'b1, ifs_pkg::ADR_TEST_FOUR, 32'h10);
    crc <= 8'hff;
    @(posedge clk) crc <= 8'h00;
    apb(1'b0, ifs_pkg::ADR_ERR_STATUS_ONE, 32'h0); check("err one", rd, 32'h3e);
    apb(1'b1, ifs_pkg::ADR_ERR_STATUS_ONE, 32'h14);
    apb(1'b0, ifs_pkg::ADR_ERR_STATUS_ONE, 32'h0); check("err clr", rd, 32'h2a);
  endtask
  task run_move;
    logic seen;
    seen = 1'b0;
    apb(1'b1, ifs_pkg::ADR_CONTROL, 32'h0004_0020);
    apb(1'b1, ifs_pkg::ADR_PROG_PTR, 32'h0);
    repeat (30) begin @(posedge clk); seen |= burst.req; end
    check("early req", {31'h0, seen}, 32'h0);
    fifo <= 1'b1;
    wait_irq();
    check("bursts", bursts, 2);
    check("burst addr", last_addr, 32'h0000_1004);
    check("io space", {30'h0, bcap.to_mem, bcap.io_space}, 32'h1);
    check("burst len", {16'h0, bcap.len}, 32'h4);
    apb(1'b0, ifs_pkg::ADR_STATUS, 32'h0); check("cause", rd[7:5], 3'h3);
    apb(1'b0, ifs_pkg::ADR_PROG_PTR, 32'h0); check("prog ptr", rd, 32'h10);
    apb(1'b0, ifs_pkg::ADR_CMD_COUNT, 32'h0); check("cmd", rd, 32'h9800_0000);
    apb(1'b0, ifs_pkg::ADR_PTR_SAVE, 32'h0); check("ptr save", rd, 32'h0000_00a5);
    repeat (20) @(posedge clk);
    check("suspended", {fetch.req, irq, halted}, 32'h3);
  endtask
  task illegal;
    apb(1'b1, ifs_pkg::ADR_PROG_PTR, 32'h10);
    wait_irq();
    apb(1'b0, ifs_pkg::ADR_STATUS, 32'h0); check("illegal", rd[7:6], 2'h2);
    apb(1'b1, ifs_pkg::ADR_CONTROL, 32'h100);
    apb(1'b1, ifs_pkg::ADR_PROG_PTR, 32'h0);
    repeat (20) @(posedge clk);
    check("low level", {31'h0, fetch.req}, 32'h0);
    apb(1'b0, ifs_pkg::ADR_STATUS, 32'h0); check("still halted", rd[7:5], 3'h5);
  endtask
  task run_mem;
    apb(1'b1, ifs_pkg::ADR_CONTROL, 32'h0004_0010);
    apb(1'b1, ifs_pkg::ADR_PROG_PTR, 32'hffff_0018);
    wait_irq();
    check("bursts 3", bursts, 3);
    check("ind addr", last_addr, 32'h0000_2000);
    check("rx space", {30'h0, bcap.to_mem, bcap.io_space}, 32'h3);
    check("ram fetch", {30'h0, fram, fbad}, 32'h2);
    apb(1'b0, ifs_pkg::ADR_TEMP, 32'h0); check("temp", rd, 32'h0000_0222);
    apb(1'b0, ifs_pkg::ADR_PROG_PTR, 32'h0); check("ptr 12", rd, 32'hffff_0034);
    hw <= 1'b1;
    apb(1'b1, ifs_pkg::ADR_PROG_PTR, 32'h0000_002c);
    wait_irq();
    hw <= 1'b0;
    apb(1'b0, ifs_pkg::ADR_STATUS, 32'h0); check("hw error", rd[7:5], 3'h7);
  endtask
  initial begin
    rst_b = 1'b0; psel = 1'b0; pen = 1'b0; pwr = 1'b0; paddr = 10'h0; pwdata = 32'h0;
    fifo = 1'b0; crc = 8'h00; hw = 1'b0; bcap = '0; fram = 1'b0; fbad = 1'b0;
    ifs_host_model_i.mem[0] = 32'h0000_0008;
    ifs_host_model_i.mem[1] = 32'h0000_1000;
    ifs_host_model_i.mem[2] = 32'h9800_0000;
    ifs_host_model_i.mem[3] = 32'h0000_00a5;
    ifs_host_model_i.mem[4] = 32'h4800_0000;
    ifs_host_model_i.mem[5] = 32'h0000_0000;
    ifs_host_model_i.mem[6] = 32'hc000_0000;
    ifs_host_model_i.mem[7] = 32'h0000_0111;
    ifs_host_model_i.mem[8] = 32'h0000_0222;
    ifs_host_model_i.mem[9] = 32'h2100_0004;
    ifs_host_model_i.mem[10] = 32'h0000_0038;
    ifs_host_model_i.mem[11] = 32'h9800_0000;
    ifs_host_model_i.mem[12] = 32'h0000_0033;
    ifs_host_model_i.mem[14] = 32'h0000_2000;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    regs();
    crc_faults();
    run_move();
    illegal();
    run_mem();
    results();
  end
endmodule
